// [ovs_front_model.sv]
// voltage front-end model: line-to-line magnitudes and evaluation ticks
`timescale 1ns/1ps
module ovs_front_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [15:0] level,
    input wire logic [1:0] sel,
    output logic [15:0] voltage_ab,
    output logic [15:0] voltage_bc,
    output logic [15:0] voltage_ca,
    output logic eval_tick
);
    logic [1:0] div_q;
    assign voltage_ab = (sel == 2'h0) ? level : ovs_pkg::PERMILLE_FULL;
    assign voltage_bc = (sel == 2'h1) ? level : ovs_pkg::PERMILLE_FULL;
    assign voltage_ca = (sel == 2'h2) ? level : ovs_pkg::PERMILLE_FULL;
    // one-cycle tick every fourth cycle, so checks fall between ticks
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end
    assign eval_tick = (div_q == 2'h3);
endmodule

// [ovs_pkg.sv]
// shared constants and register map of the overvoltage stage block
package ovs_pkg;

    // ------------------------------------------------------------
    // register map (word addresses on the plain register port)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_PASS = 8'h00;
    localparam logic [7:0] REG_FORCE = 8'h01;
    localparam logic [7:0] REG_GROUP = 8'h02;
    localparam logic [7:0] REG_UMAX = 8'h03;
    localparam logic [7:0] REG_CLEAR = 8'h04;
    localparam logic [7:0] STAGE_BASE = 8'h10;
    localparam logic [7:0] REC_BASE = 8'h40;
    localparam logic [3:0] ST_PICK1 = 4'h0;
    localparam logic [3:0] ST_PICK2 = 4'h1;
    localparam logic [3:0] ST_DLY1 = 4'h2;
    localparam logic [3:0] ST_DLY2 = 4'h3;
    localparam logic [3:0] ST_HYST = 4'h4;
    localparam logic [3:0] ST_REL = 4'h5;
    localparam logic [3:0] ST_STATUS = 4'h6;
    localparam logic [3:0] ST_SCNT = 4'h7;
    localparam logic [3:0] ST_TCNT = 4'h8;
    localparam logic [3:0] ST_PRIM = 4'h9;
    localparam logic [2:0] REC_DATE = 3'h0;
    localparam logic [2:0] REC_TIME = 3'h1;
    localparam logic [2:0] REC_PEAK = 3'h2;
    localparam logic [2:0] REC_META = 3'h3;

    // ------------------------------------------------------------
    // codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] STAT_IDLE = 2'h0;
    localparam logic [1:0] STAT_BLOCKED = 2'h1;
    localparam logic [1:0] STAT_STARTED = 2'h2;
    localparam logic [1:0] STAT_TRIPPED = 2'h3;
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_DIGITAL = 3'h1;
    localparam logic [2:0] SRC_VIRT_IN = 3'h2;
    localparam logic [2:0] SRC_INDICATOR = 3'h3;
    localparam logic [2:0] SRC_VIRT_OUT = 3'h4;
    // voltages and pick-ups are in 0.1 % of nominal, 16'h03E8 = 100 %
    localparam logic [15:0] PERMILLE_FULL = 16'h03E8;
    localparam logic [7:0] PCT_FULL = 8'h64;
    localparam logic [7:0] HYST_DEFAULT = 8'h1E;
    localparam logic [15:0] PICK_DEFAULT = 16'h04B0;
    localparam logic [15:0] DLY_DEFAULT = 16'h000A;
    localparam logic [15:0] REL_DEFAULT = 16'h0000;
    // arbitrary neutral unlock key
    localparam logic [31:0] PASS_KEY = 32'h0000_1234;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 64'd10_000_000;
    localparam longint FORCE_TIMEOUT_S = 64'd300;
    localparam longint FORCE_TIMEOUT_CYC = FORCE_TIMEOUT_S * CLK_HZ;

endpackage

// [ovs_tb.sv]
// self-checking bench for the overvoltage stage block
`timescale 1ns/1ps
module tb;
    logic sys_clk, rst_n, reg_wr, reg_rd, eval_tick, force_active;
    logic [15:0] level, voltage_ab, voltage_bc, voltage_ca;
    logic [1:0] sel;
    logic [2:0] block_in, start_out, trip_out;
    logic [7:0] reg_addr, gsel;
    logic [31:0] reg_wdata, reg_rdata;
    int errors, comparisons;

    ovs_front_model ovs_front_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .level(level), .sel(sel),
        .voltage_ab(voltage_ab), .voltage_bc(voltage_bc), .voltage_ca(voltage_ca), .eval_tick(eval_tick));
    ovs_top #(.FORCE_TIMEOUT_CYC(50)) ovs_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .eval_tick(eval_tick),
        .voltage_ab(voltage_ab), .voltage_bc(voltage_bc), .voltage_ca(voltage_ca), .block_in(block_in),
        .digital_in(gsel), .virtual_input_n(gsel), .indicator_signal_n(gsel), .virtual_output_n(gsel),
        .stamp_date(32'h0002_0304), .stamp_time_ms(32'h0000_0555), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .start_out(start_out), .trip_out(trip_out), .force_active(force_active));

    // ----------------------------------------
    // bus cycles and comparison
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // new level, then wait n ticks plus the output latency
    task automatic lv(input logic [15:0] val, input int n);
        @(posedge sys_clk);
        level <= val;
        repeat (n) begin
            @(posedge sys_clk);
            while (eval_tick !== 1'b1) @(posedge sys_clk);
        end
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic t_regs();
        wr(8'h10, 32'h0000_0400);
        rc(8'h10, 32'h0000_04B0);
        rc(8'h14, 32'h0000_001E);
        rc(8'hF0, 32'h0000_0000);
        wr(ovs_pkg::REG_PASS, ovs_pkg::PASS_KEY);
        // pick 110 %, 3 % band stays above nominal
        wr(8'h10, 32'h0000_044C);
        // four ticks so the trip can only come from a resumed count
        wr(8'h12, 32'h0000_0004);
        wr(8'h15, 32'h0000_0005);
        wr(8'h25, 32'h0000_0005);
        rc(8'h25, 32'h0000_0000);
        rc(8'h19, 32'h0000_2AF8);
        $display("test regs done");
    endtask
    task automatic t_trip();
        lv(16'h047E, 2);
        chk(32'({trip_out, start_out}), 32'h0000_0001);
        rc(ovs_pkg::REG_UMAX, 32'h0000_047E);
        lv(16'h03E8, 2);
        chk(32'({trip_out, start_out}), 32'h0000_0000);
        lv(16'h047E, 1);
        chk(32'({trip_out, start_out}), 32'h0000_0009);
        lv(16'h042E, 1);
        chk(32'({trip_out, start_out}), 32'h0000_0009);
        lv(16'h0424, 1);
        chk(32'({trip_out, start_out}), 32'h0000_0000);
        rc(8'h17, 32'h0000_0002);
        rc(8'h18, 32'h0000_0001);
        rc(8'h40, 32'h0002_0304);
        rc(8'h42, 32'h0000_047E);
        rc(8'h43, 32'h0002_004B);
        wr(ovs_pkg::REG_CLEAR, 32'h0000_0003);
        rc(8'h17, 32'h0000_0000);
        $display("test trip done");
    endtask
    task automatic t_block();
        @(posedge sys_clk);
        block_in <= 3'b001;
        lv(16'h047E, 1);
        chk(32'({trip_out, start_out}), 32'h0000_0000);
        rc(8'h16, 32'(ovs_pkg::STAT_BLOCKED));
        @(posedge sys_clk);
        block_in <= 3'b000;
        lv(16'h03E8, 1);
        $display("test block done");
    endtask
    task automatic t_group();
        @(posedge sys_clk);
        gsel <= 8'h01;
        for (int s = 1; s < 5; s++) begin
            wr(ovs_pkg::REG_GROUP, 32'(s << 4));
            rc(ovs_pkg::REG_GROUP, 32'h0001_0000 | 32'(s << 4));
        end
        @(posedge sys_clk);
        gsel <= 8'h00;
        rc(ovs_pkg::REG_GROUP, 32'h0000_0040);
        wr(ovs_pkg::REG_GROUP, 32'h0000_0001);
        rc(ovs_pkg::REG_GROUP, 32'h0001_0001);
        // group two keeps the default pick-up, so 115 % stays quiet
        lv(16'h047E, 1);
        chk(32'({trip_out, start_out}), 32'h0000_0000);
        lv(16'h03E8, 1);
        wr(ovs_pkg::REG_GROUP, 32'h0000_0000);
        $display("test group done");
    endtask
    task automatic t_force();
        wr(8'h16, 32'h0000_0003);
        rc(8'h16, 32'(ovs_pkg::STAT_IDLE));
        wr(ovs_pkg::REG_FORCE, 32'h0000_0001);
        wr(8'h16, 32'h0000_0003);
        rc(8'h16, 32'(ovs_pkg::STAT_TRIPPED));
        chk(32'({force_active, trip_out}), 32'h0000_0009);
        repeat (60) @(posedge sys_clk);
        #1 chk(32'(force_active), 32'h0000_0000);
        $display("test force done");
    endtask

    task automatic results();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        rst_n = 1'b0;
        level = 16'h03E8;
        sel = 2'h1;
        block_in = 3'b000;
        gsel = 8'h00;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        errors = 0;
        comparisons = 0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_regs();
        t_trip();
        t_block();
        t_group();
        t_force();
        results();
    end
    // run needs well under 1000 cycles
    initial begin
        #(100 * 20000);
        errors++;
        results();
    end
endmodule

// [ovs_top.sv]
// three definite-time overvoltage stages with register port and fault records
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps

// Functional notes
// - stage input is the fundamental magnitude of the three line-to-line voltages
// - the largest line-to-line magnitude is the supervised value, readable
// - a stage starts when any line voltage exceeds its pick-up
// - a stage trips once start persists for its operation time
// - three independent definite-time stages
// - only stage one has a release hold time
// - stage one keeps its delay count until the release hold elapses
// - a returning fault resumes counting from the kept value
// - release only below pick-up reduced by the dead band, default 3 %
// - two setting groups, chosen manually or by a selected input
// - group source: none, digital, virtual input, indicator, virtual output
// - status idle, blocked, started, tripped; forcing only with the force flag
// - one shared force flag, cleared after five minutes
// - start and trip event counters per stage, clearable by software
// - pick-up set in 0.1 % of nominal, also shown in primary volts
// - settable values accept writes only after the password unlock
// - last eight faults record stamp, peak, elapsed percent, group; one per tick, only the lowest stage closing in it
module ovs_top #(
    parameter longint FORCE_TIMEOUT_CYC = ovs_pkg::FORCE_TIMEOUT_CYC,
    parameter logic [15:0] VNOM_PRIMARY = 16'h2710
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic eval_tick,
    input wire logic [15:0] voltage_ab,
    input wire logic [15:0] voltage_bc,
    input wire logic [15:0] voltage_ca,
    input wire logic [2:0] block_in,
    input wire logic [7:0] digital_in,
    input wire logic [7:0] virtual_input_n,
    input wire logic [7:0] indicator_signal_n,
    input wire logic [7:0] virtual_output_n,
    input wire logic [31:0] stamp_date,
    input wire logic [31:0] stamp_time_ms,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [2:0] start_out,
    output logic [2:0] trip_out,
    output logic force_active
);

    typedef struct packed {
        logic auth;
        logic force_on;
        logic [31:0] force_cnt;
        logic manual_grp;
        logic [2:0] src_type;
        logic [2:0] src_idx;
        logic grp2;
        logic [15:0] umax;
        logic [2:0][15:0] pick1;
        logic [2:0][15:0] pick2;
        logic [2:0][15:0] dly1;
        logic [2:0][15:0] dly2;
        logic [2:0][7:0] hyst;
        logic [2:0][15:0] cnt;
        logic [2:0][15:0] scnt;
        logic [2:0][15:0] tcnt;
        logic [2:0][15:0] peak;
        logic [15:0] rel_hold;
        logic [15:0] rel_cnt;
        logic [2:0] fault;
        logic [2:0] start;
        logic [2:0] trip;
        logic [2:0] blocked;
        logic [2:0][1:0] forced;
        logic [2:0] wr_ptr;
        logic [7:0][31:0] rec_date;
        logic [7:0][31:0] rec_time;
        logic [7:0][15:0] rec_peak;
        logic [7:0][7:0] rec_pct;
        logic [7:0] rec_grp;
        logic [7:0][1:0] rec_stage;
        logic [31:0] rdata;
    } ovs_state_s;

    ovs_state_s s_q;
    ovs_state_s s_d;
    logic [1:0] rst_sync_q;
    logic rst_sys_n;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_sys_n = rst_sync_q[1];

    function automatic logic [15:0] max3(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        logic [15:0] m;
        m = (a > b) ? a : b;
        return (m > c) ? m : c;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] vmax;
        logic [15:0] pk;
        logic [15:0] dl;
        logic [31:0] rel_lvl;
        logic flt;
        logic rec_done;
        logic sel_bit;
        logic [1:0] si;
        logic [3:0] so;
        logic [2:0] ri;
        logic [1:0] st;
        vmax = 16'h0000;
        pk = 16'h0000;
        dl = 16'h0000;
        rel_lvl = 32'h0000_0000;
        flt = 1'b0;
        rec_done = 1'b0;
        sel_bit = 1'b0;
        si = 2'(reg_addr[5:4] - 2'h1);
        so = reg_addr[3:0];
        ri = reg_addr[5:3];
        st = 2'h0;
        s_d = s_q;
        s_d.rdata = 32'h0000_0000;

        vmax = max3(voltage_ab, voltage_bc, voltage_ca);
        if (eval_tick) begin
            s_d.umax = vmax;
        end

        if (s_q.force_on) begin
            s_d.force_cnt = s_q.force_cnt + 32'h0000_0001;
            if (s_q.force_cnt >= 32'(FORCE_TIMEOUT_CYC - 64'd1)) begin
                s_d.force_on = 1'b0;
                s_d.force_cnt = 32'h0000_0000;
            end
        end

        // ---------------- register writes ----------------
        if (reg_wr) begin
            if (reg_addr == ovs_pkg::REG_PASS) begin
                s_d.auth = (reg_wdata == ovs_pkg::PASS_KEY);
            end else if (reg_addr == ovs_pkg::REG_CLEAR) begin
                // software clear, an increment in the same cycle wins below
                for (int i = 0; i < 3; i++) begin
                    if (reg_wdata[i]) begin
                        s_d.scnt[i] = 16'h0000;
                        s_d.tcnt[i] = 16'h0000;
                    end
                end
            end else if (s_q.auth && reg_addr == ovs_pkg::REG_FORCE) begin
                s_d.force_on = reg_wdata[0];
                s_d.force_cnt = 32'h0000_0000;
            end else if (s_q.auth && reg_addr == ovs_pkg::REG_GROUP) begin
                s_d.manual_grp = reg_wdata[0];
                s_d.src_type = reg_wdata[6:4];
                s_d.src_idx = reg_wdata[10:8];
            end else if (reg_addr >= ovs_pkg::STAGE_BASE && reg_addr < ovs_pkg::REC_BASE) begin
                if (s_q.auth) begin
                    case (so)
                        ovs_pkg::ST_PICK1: s_d.pick1[si] = reg_wdata[15:0];
                        ovs_pkg::ST_PICK2: s_d.pick2[si] = reg_wdata[15:0];
                        ovs_pkg::ST_DLY1: s_d.dly1[si] = reg_wdata[15:0];
                        ovs_pkg::ST_DLY2: s_d.dly2[si] = reg_wdata[15:0];
                        ovs_pkg::ST_HYST: s_d.hyst[si] = reg_wdata[7:0];
                        // release hold exists for stage one only
                        ovs_pkg::ST_REL: if (si == 2'h0) s_d.rel_hold = reg_wdata[15:0];
                        default: s_d.rel_hold = s_d.rel_hold;
                    endcase
                end
                if (so == ovs_pkg::ST_STATUS && s_q.force_on) begin
                    s_d.forced[si] = (reg_wdata[1:0] == ovs_pkg::STAT_STARTED ||
                                      reg_wdata[1:0] == ovs_pkg::STAT_TRIPPED) ? reg_wdata[1:0] : 2'h0;
                end
            end
        end
        if (!s_d.force_on) begin
            s_d.forced = '0;
        end

        // active group from manual bit or selected signal
        case (s_q.src_type)
            ovs_pkg::SRC_DIGITAL: sel_bit = digital_in[s_q.src_idx];
            ovs_pkg::SRC_VIRT_IN: sel_bit = virtual_input_n[s_q.src_idx];
            ovs_pkg::SRC_INDICATOR: sel_bit = indicator_signal_n[s_q.src_idx];
            ovs_pkg::SRC_VIRT_OUT: sel_bit = virtual_output_n[s_q.src_idx];
            default: sel_bit = s_q.manual_grp;
        endcase
        s_d.grp2 = sel_bit;

        // ---------------- stages ----------------
        // three stages share one evaluation loop
        for (int i = 0; i < 3; i++) begin
            pk = s_q.grp2 ? s_q.pick2[i] : s_q.pick1[i];
            dl = s_q.grp2 ? s_q.dly2[i] : s_q.dly1[i];
            rel_lvl = 32'(pk) * (32'(ovs_pkg::PERMILLE_FULL) - 32'(s_q.hyst[i]));
            if (eval_tick) begin
                s_d.blocked[i] = block_in[i];
                if (block_in[i]) begin
                    flt = 1'b0;
                    s_d.cnt[i] = 16'h0000;
                    if (i == 0) s_d.rel_cnt = 16'h0000;
                end else begin
                    // pick-up above setting, release below dead band
                    if (s_q.fault[i]) begin
                        flt = (32'(vmax) * 32'(ovs_pkg::PERMILLE_FULL)) >= rel_lvl;
                    end else begin
                        flt = vmax > pk;
                    end
                    if (flt) begin
                        // definite-time count, resumes from kept value
                        if (s_q.cnt[i] < dl) s_d.cnt[i] = s_q.cnt[i] + 16'h0001;
                        if (i == 0) s_d.rel_cnt = 16'h0000;
                        s_d.peak[i] = (!s_q.fault[i] || vmax > s_q.peak[i]) ? vmax : s_q.peak[i];
                    end else if (i == 0 && s_q.rel_cnt < s_q.rel_hold) begin
                        // count kept while release hold runs
                        s_d.rel_cnt = s_q.rel_cnt + 16'h0001;
                    end else begin
                        s_d.cnt[i] = 16'h0000;
                    end
                end
                // close of a fault episode goes into the ring
                if (s_q.fault[i] && !flt && !rec_done) begin
                    rec_done = 1'b1;
                    s_d.rec_date[s_q.wr_ptr] = stamp_date;
                    s_d.rec_time[s_q.wr_ptr] = stamp_time_ms;
                    s_d.rec_peak[s_q.wr_ptr] = s_q.peak[i];
                    s_d.rec_pct[s_q.wr_ptr] = (s_q.trip[i] || dl == 16'h0000) ? ovs_pkg::PCT_FULL :
                        8'((32'(s_q.cnt[i]) * 32'(ovs_pkg::PCT_FULL)) / 32'(dl));
                    s_d.rec_grp[s_q.wr_ptr] = s_q.grp2;
                    s_d.rec_stage[s_q.wr_ptr] = 2'(i);
                    s_d.wr_ptr = s_q.wr_ptr + 3'h1;
                end
                s_d.fault[i] = flt;
                s_d.start[i] = flt;
                s_d.trip[i] = flt && s_d.cnt[i] >= dl;
            end
            // forced outputs for test, block still wins
            if (s_d.blocked[i]) begin
                s_d.start[i] = 1'b0;
                s_d.trip[i] = 1'b0;
            end else if (s_d.forced[i] != 2'h0) begin
                s_d.start[i] = 1'b1;
                s_d.trip[i] = (s_d.forced[i] == ovs_pkg::STAT_TRIPPED);
            end else if (s_q.forced[i] != 2'h0) begin
                s_d.start[i] = s_q.fault[i];
                s_d.trip[i] = s_q.fault[i] && s_q.cnt[i] >= dl;
            end
            if (s_d.start[i] && !s_q.start[i] && s_d.scnt[i] != 16'hFFFF) begin
                s_d.scnt[i] = s_d.scnt[i] + 16'h0001;
            end
            if (s_d.trip[i] && !s_q.trip[i] && s_d.tcnt[i] != 16'hFFFF) begin
                s_d.tcnt[i] = s_d.tcnt[i] + 16'h0001;
            end
        end

        // ---------------- register reads ----------------
        if (reg_rd) begin
            if (reg_addr == ovs_pkg::REG_PASS) begin
                s_d.rdata = {31'h0000_0000, s_q.auth};
            end else if (reg_addr == ovs_pkg::REG_FORCE) begin
                s_d.rdata = {31'h0000_0000, s_q.force_on};
            end else if (reg_addr == ovs_pkg::REG_GROUP) begin
                s_d.rdata = {15'h0000, s_q.grp2, 5'h00, s_q.src_idx, 1'b0, s_q.src_type, 3'h0, s_q.manual_grp};
            end else if (reg_addr == ovs_pkg::REG_UMAX) begin
                s_d.rdata = {16'h0000, s_q.umax};
            end else if (reg_addr >= ovs_pkg::STAGE_BASE && reg_addr < ovs_pkg::REC_BASE) begin
                st = s_q.blocked[si] ? ovs_pkg::STAT_BLOCKED :
                     s_q.trip[si] ? ovs_pkg::STAT_TRIPPED :
                     s_q.start[si] ? ovs_pkg::STAT_STARTED : ovs_pkg::STAT_IDLE;
                case (so)
                    ovs_pkg::ST_PICK1: s_d.rdata = {16'h0000, s_q.pick1[si]};
                    ovs_pkg::ST_PICK2: s_d.rdata = {16'h0000, s_q.pick2[si]};
                    ovs_pkg::ST_DLY1: s_d.rdata = {16'h0000, s_q.dly1[si]};
                    ovs_pkg::ST_DLY2: s_d.rdata = {16'h0000, s_q.dly2[si]};
                    ovs_pkg::ST_HYST: s_d.rdata = {24'h00_0000, s_q.hyst[si]};
                    ovs_pkg::ST_REL: s_d.rdata = (si == 2'h0) ? {16'h0000, s_q.rel_hold} : 32'h0000_0000;
                    ovs_pkg::ST_STATUS: s_d.rdata = {30'h0000_0000, st};
                    ovs_pkg::ST_SCNT: s_d.rdata = {16'h0000, s_q.scnt[si]};
                    ovs_pkg::ST_TCNT: s_d.rdata = {16'h0000, s_q.tcnt[si]};
                    // active pick-up scaled to primary volts
                    ovs_pkg::ST_PRIM: s_d.rdata = (32'(s_q.grp2 ? s_q.pick2[si] : s_q.pick1[si]) *
                        32'(VNOM_PRIMARY)) / 32'(ovs_pkg::PERMILLE_FULL);
                    default: s_d.rdata = 32'h0000_0000;
                endcase
            end else if (reg_addr >= ovs_pkg::REC_BASE && reg_addr[7] == 1'b0) begin
                case (reg_addr[2:0])
                    ovs_pkg::REC_DATE: s_d.rdata = s_q.rec_date[ri];
                    ovs_pkg::REC_TIME: s_d.rdata = s_q.rec_time[ri];
                    ovs_pkg::REC_PEAK: s_d.rdata = {16'h0000, s_q.rec_peak[ri]};
                    ovs_pkg::REC_META: s_d.rdata = {13'h0000, s_q.wr_ptr, 2'h0, s_q.rec_stage[ri],
                        3'h0, s_q.rec_grp[ri], s_q.rec_pct[ri]};
                    default: s_d.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            s_q <= '0;
            s_q.pick1 <= {3{ovs_pkg::PICK_DEFAULT}};
            s_q.pick2 <= {3{ovs_pkg::PICK_DEFAULT}};
            s_q.dly1 <= {3{ovs_pkg::DLY_DEFAULT}};
            s_q.dly2 <= {3{ovs_pkg::DLY_DEFAULT}};
            s_q.hyst <= {3{ovs_pkg::HYST_DEFAULT}};
            s_q.rel_hold <= ovs_pkg::REL_DEFAULT;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign start_out = s_q.start;
    assign trip_out = s_q.trip;
    assign force_active = s_q.force_on;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_sys_n);

    sequence s_locked_pick_write;
        reg_wr && !s_q.auth && reg_addr == ovs_pkg::STAGE_BASE;
    endsequence

    sequence s_held_count;
        eval_tick && !block_in[0] && s_q.cnt[0] != 16'h0000 && s_q.rel_cnt < s_q.rel_hold;
    endsequence

    AST_UMAX_IS_MAX: assert property (eval_tick |=> s_q.umax == max3($past(voltage_ab),
        $past(voltage_bc), $past(voltage_ca))) else $error("supervised value is not the largest voltage");
    AST_PICKUP_STARTS: assert property (eval_tick && !block_in[0] && !s_q.force_on && !s_q.grp2 &&
        max3(voltage_ab, voltage_bc, voltage_ca) > s_q.pick1[0] |=> start_out[0])
        else $error("stage one failed to start above pick-up");
    AST_TRIP_WITH_START: assert property (trip_out[0] |-> start_out[0])
        else $error("trip without start");
    AST_BLOCK_QUIETS: assert property (eval_tick && block_in[0] |=> !start_out[0] && !trip_out[0])
        else $error("blocked stage still drives outputs");
    AST_FORCE_GATES_STATUS: assert property (!s_q.force_on |-> s_q.forced == '0)
        else $error("forced status present without force flag");
    AST_FORCE_TIMEOUT: assert property (s_q.force_on |-> s_q.force_cnt < 32'(FORCE_TIMEOUT_CYC))
        else $error("force flag outlived its timeout");
    AST_LOCKED_WRITE: assert property (s_locked_pick_write |=> $stable(s_q.pick1[0]))
        else $error("pick-up changed without unlock");
    AST_HOLD_KEEPS_COUNT: assert property (s_held_count |=> s_q.cnt[0] != 16'h0000)
        else $error("stage one count lost during release hold");
    AST_RING_STEP: assert property (s_q.wr_ptr != $past(s_q.wr_ptr) |->
        s_q.wr_ptr == 3'($past(s_q.wr_ptr) + 3'h1)) else $error("record pointer skipped");
    AST_CLEAR_COUNT: assert property (reg_wr && reg_addr == ovs_pkg::REG_CLEAR && reg_wdata[1] |=>
        s_q.scnt[1] <= 16'h0001) else $error("start counter not cleared");

endmodule
